// ---- common/vsmd_blk_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface vsmd_blk_if;
	logic [23:1] addr;
	logic [5:0] am;
	logic wr;
	logic iack;
	logic pfail;
	vsmd_pkg::vsmd_blkcfg_t cfg;
	logic hit;
	logic [1:0] pair;

	modport dec (
		input addr,
		input am,
		input wr,
		input iack,
		input pfail,
		input cfg,
		output hit,
		output pair
	);

	modport ctl (
		output addr,
		output am,
		output wr,
		output iack,
		output pfail,
		output cfg,
		input hit,
		input pair
	);
endinterface
`default_nettype wire

// ---- common/vsmd_params.svh ----
`ifndef VSMD_PARAMS_SVH
`define VSMD_PARAMS_SVH

`define VSMD_CLK_PERIOD_NS 8
`define VSMD_NUM_BLOCKS 3
`define VSMD_SOCKETS_PER_BLOCK 8

// register byte offsets, one aligned 32-bit word each
`define VSMD_REG_CFG0 4'h0
`define VSMD_REG_CFG1 4'h4
`define VSMD_REG_CFG2 4'h8
`define VSMD_REG_STATUS 4'hC

// block configuration word fields
`define VSMD_CFG_WIDTH 19
`define VSMD_CFG_BASE_LSB 0
`define VSMD_CFG_CAP_LSB 8
`define VSMD_CFG_SUP_BIT 10
`define VSMD_CFG_USR_BIT 11
`define VSMD_CFG_DAT_BIT 12
`define VSMD_CFG_PRG_BIT 13
`define VSMD_CFG_RDONLY_BIT 14
`define VSMD_CFG_BACKUP_BIT 15
`define VSMD_CFG_ATIME_LSB 16
// all classes accepted, read-write, no backup, slowest access time
`define VSMD_CFG_RESET 19'h53C00

// status word fields
`define VSMD_STS_LED_LSB 0
`define VSMD_STS_PFAIL_BIT 3
`define VSMD_STS_STATE_LSB 4
`define VSMD_STS_DTACK_BIT 8

// address modifier decode
`define VSMD_AM_EXT 3'h1
`define VSMD_AM_SHORT 3'h5
`define VSMD_AM_STD 3'h7
`define VSMD_AM_DATA 2'h1
`define VSMD_AM_PROG 2'h2

// access time selections, code 0..5
`define VSMD_TACC_100_NS 100
`define VSMD_TACC_150_NS 150
`define VSMD_TACC_200_NS 200
`define VSMD_TACC_250_NS 250
`define VSMD_TACC_350_NS 350
`define VSMD_TACC_500_NS 500
`define VSMD_NS2CYC(t) (((t) + `VSMD_CLK_PERIOD_NS - 1) / `VSMD_CLK_PERIOD_NS)
`define VSMD_TACC_100_CYC `VSMD_NS2CYC(`VSMD_TACC_100_NS)
`define VSMD_TACC_150_CYC `VSMD_NS2CYC(`VSMD_TACC_150_NS)
`define VSMD_TACC_200_CYC `VSMD_NS2CYC(`VSMD_TACC_200_NS)
`define VSMD_TACC_250_CYC `VSMD_NS2CYC(`VSMD_TACC_250_NS)
`define VSMD_TACC_350_CYC `VSMD_NS2CYC(`VSMD_TACC_350_NS)
`define VSMD_TACC_500_CYC `VSMD_NS2CYC(`VSMD_TACC_500_NS)

`endif

// ---- common/vsmd_pkg.sv ----
`default_nettype none
package vsmd_pkg;

	typedef struct packed {
		logic [2:0] atime;
		logic backup;
		logic rd_only;
		logic prg_en;
		logic dat_en;
		logic usr_en;
		logic sup_en;
		logic [1:0] cap;
		logic [7:0] base;
	} vsmd_blkcfg_t;

	typedef enum logic [3:0] {
		AMODE_OTHER = 4'h1,
		AMODE_SHORT = 4'h2,
		AMODE_STD = 4'h4,
		AMODE_EXT = 4'h8
	} vsmd_amode_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_ACCESS = 4'h2,
		ST_ACK = 4'h4,
		ST_HOLD = 4'h8
	} vsmd_state_t;

endpackage
`default_nettype wire

// ---- rtl/vsmd_block_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "vsmd_params.svh"
module vsmd_block_decode (
	vsmd_blk_if.dec bus
);
	vsmd_pkg::vsmd_amode_t amode;
	wire logic code_ok;
	wire logic class_ok;
	wire logic [7:0] cmp_mask;
	wire logic base_ok;
	wire logic wr_ok;
	wire logic pf_ok;

	assign amode = (bus.am[5:3] == `VSMD_AM_STD) ? vsmd_pkg::AMODE_STD : // R6
		(bus.am[5:3] == `VSMD_AM_SHORT) ? vsmd_pkg::AMODE_SHORT :
		(bus.am[5:3] == `VSMD_AM_EXT) ? vsmd_pkg::AMODE_EXT : vsmd_pkg::AMODE_OTHER;
	// only 39/3A/3D/3E pass: data or program, user or supervisor
	assign code_ok = (amode == vsmd_pkg::AMODE_STD) &&
		(bus.am[1:0] == `VSMD_AM_DATA || bus.am[1:0] == `VSMD_AM_PROG); // R5 R6
	assign class_ok = (bus.am[2] ? bus.cfg.sup_en : bus.cfg.usr_en) &
		((bus.am[1:0] == `VSMD_AM_DATA) ? bus.cfg.dat_en : bus.cfg.prg_en); // R7
	// lines below the block's total size take no part in the base match
	assign cmp_mask = 8'hFF << bus.cfg.cap; // R3
	assign base_ok = (((bus.addr[23:16] ^ bus.cfg.base) & cmp_mask) == 8'h00); // R4
	assign wr_ok = ~(bus.wr & bus.cfg.rd_only); // R12 R17
	assign pf_ok = ~(bus.pfail & bus.cfg.backup); // R14
	assign bus.hit = ~bus.iack & code_ok & class_ok & base_ok & wr_ok & pf_ok; // R8
	// socket pair index sits just above the lines inside one unit
	assign bus.pair = (bus.cfg.cap == 2'h0) ? bus.addr[15:14] : // R2
		(bus.cfg.cap == 2'h1) ? bus.addr[16:15] :
		(bus.cfg.cap == 2'h2) ? bus.addr[17:16] : bus.addr[18:17];
endmodule // vsmd_block_decode
`default_nettype wire

// ---- rtl/vsmd_top.sv ----
// Contract
// R1 - three independent blocks of eight sockets
// R2 - unit size 8K..64K steers unit decode
// R3 - base aligned to eight unit capacities
// R4 - base compared across upper 24-bit address
// R5 - accept only four standard modifier codes
// R6 - only standard addressing selects a block
// R7 - per-block supervisor/user and data/program filter
// R8 - interrupt acknowledge never a memory access
// R9 - grant and acknowledge chains pass through
// R10 - data strobes enable matching byte sockets
// R11 - read, write, read-modify-write keep selection
// R12 - read-only block refuses writes
// R13 - six selectable access times per block
// R14 - power fail drops backup block enable
// R15 - one access indicator per block
// R16 - starred bus signals are active low
// R17 - protected write leaves board unselected
// R18 - access time counted from chip enable
// R19 - acknowledge after access time, release on strobes
// R20 - even socket upper lane, odd lower
`timescale 1ns/1ps
`default_nettype none
`include "vsmd_params.svh"
module vsmd_top #(
	parameter int NUM_BLOCKS = `VSMD_NUM_BLOCKS,
	parameter int SOCKETS = `VSMD_SOCKETS_PER_BLOCK
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic CLK_EN,
	input wire logic [3:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [23:1] VME_ADDR,
	input wire logic [5:0] VME_AM,
	input wire logic VME_AS_N,
	input wire logic VME_DS0_N,
	input wire logic VME_DS1_N,
	input wire logic VME_WRITE_N,
	input wire logic VME_IACK_N,
	input wire logic VME_IACKIN_N,
	output logic VME_IACKOUT_N,
	input wire logic [3:0] VME_BG_IN_N,
	output logic [3:0] VME_BG_OUT_N,
	output logic VME_DTACK_N,
	output logic VME_DTACK_OE,
	input wire logic POWER_FAIL,
	output logic [NUM_BLOCKS*SOCKETS-1:0] MEM_CE_N,
	output logic MEM_OE_N,
	output logic MEM_WE_N,
	output logic [15:0] MEM_ADDR,
	output logic [NUM_BLOCKS-1:0] SECONDARY_CHIP_ENABLE,
	output logic [NUM_BLOCKS-1:0] ACCESS_LED
);
	localparam int CW = `VSMD_CFG_WIDTH;

	logic [CW-1:0] cfg_reg [NUM_BLOCKS];
	logic avs_done;
	vsmd_pkg::vsmd_state_t state;
	vsmd_pkg::vsmd_state_t next_state;
	logic [NUM_BLOCKS-1:0] sel_blk;
	logic [NUM_BLOCKS-1:0] next_blk;
	logic [1:0] sel_pair;
	logic [1:0] next_pair;
	logic [1:0] sel_lane;
	logic [1:0] next_lane;
	logic sel_wr;
	logic next_wr;
	logic [6:0] need_cnt;
	logic [6:0] next_need;
	logic [6:0] cnt;
	logic [6:0] next_cnt;
	logic [15:0] next_addr;
	logic [1:0] pick_pair;
	logic [2:0] pick_atime;

	wire logic [NUM_BLOCKS-1:0] hit_vec;
	wire logic [1:0] pair_vec [NUM_BLOCKS];
	wire logic [2:0] atime_vec [NUM_BLOCKS];
	wire logic [NUM_BLOCKS-1:0] pick;
	wire logic as_on;
	wire logic [1:0] ds_on;
	wire logic ds_any;
	wire logic cyc_wr;
	wire logic cnt_done;
	wire logic rehit;
	wire logic sel_any;
	wire logic [NUM_BLOCKS*SOCKETS-1:0] next_ce_n;
	wire logic [NUM_BLOCKS-1:0] next_sce;
	wire logic avs_req;
	wire logic wr_cfg0;
	wire logic wr_cfg1;
	wire logic wr_cfg2;
	wire logic [31:0] rd_mux;
	wire logic [31:0] status_word;

	// every starred backplane line is active low
	assign as_on = ~VME_AS_N; // R16
	assign ds_on = {~VME_DS1_N, ~VME_DS0_N}; // R16
	assign ds_any = |ds_on;
	assign cyc_wr = ~VME_WRITE_N; // R16

	// daisy chains ride straight through, the board never arbitrates
	assign VME_BG_OUT_N = VME_BG_IN_N; // R9
	assign VME_IACKOUT_N = VME_IACKIN_N; // R9

	genvar b;
	generate
		for (b = 0; b < NUM_BLOCKS; b++) begin : gen_blk
			vsmd_blk_if bif ();

			assign bif.addr = VME_ADDR;
			assign bif.am = VME_AM;
			assign bif.wr = cyc_wr;
			assign bif.iack = ~VME_IACK_N; // R8
			assign bif.pfail = POWER_FAIL;
			assign bif.cfg = vsmd_pkg::vsmd_blkcfg_t'(cfg_reg[b]);
			assign hit_vec[b] = bif.hit; // R1
			assign pair_vec[b] = bif.pair;
			assign atime_vec[b] = cfg_reg[b][`VSMD_CFG_ATIME_LSB +: 3];
			// backed-up block goes to standby while the supply is failing
			assign next_sce[b] = ~(POWER_FAIL & cfg_reg[b][`VSMD_CFG_BACKUP_BIT]); // R14

			vsmd_block_decode u_dec (
				.bus(bif)
			);
		end
	endgenerate

	// overlapping bases: the lowest-numbered block wins
	assign pick = hit_vec & (~hit_vec + 3'h1);

	always_comb begin
		pick_pair = 2'h0;
		pick_atime = 3'h0;
		for (int i = 0; i < NUM_BLOCKS; i++) begin
			if (pick[i]) begin
				pick_pair = pair_vec[i];
				pick_atime = atime_vec[i];
			end
		end
	end

	function automatic logic [6:0] tacc_cycles(input logic [2:0] code);
		logic [6:0] c;
		c = 7'(`VSMD_TACC_500_CYC);
		case (code)
			3'h0: c = 7'(`VSMD_TACC_100_CYC);
			3'h1: c = 7'(`VSMD_TACC_150_CYC);
			3'h2: c = 7'(`VSMD_TACC_200_CYC);
			3'h3: c = 7'(`VSMD_TACC_250_CYC);
			3'h4: c = 7'(`VSMD_TACC_350_CYC);
			default: c = 7'(`VSMD_TACC_500_CYC);
		endcase
		return c;
	endfunction

	// unknown codes fall back to the slowest time so data is never early
	assign cnt_done = (cnt == need_cnt - 7'h01); // R13 R18
	// second phase of a locked cycle must still be allowed by its block
	assign rehit = |(hit_vec & sel_blk); // R11 R12

	always_comb begin
		next_state = state;
		next_blk = sel_blk;
		next_pair = sel_pair;
		next_lane = sel_lane;
		next_wr = sel_wr;
		next_need = need_cnt;
		next_cnt = cnt;
		next_addr = MEM_ADDR;
		case (state)
			vsmd_pkg::ST_IDLE: begin
				if (as_on && ds_any && (|pick)) begin
					next_state = vsmd_pkg::ST_ACCESS;
					next_blk = pick;
					next_pair = pick_pair;
					next_lane = ds_on; // R10
					next_wr = cyc_wr;
					next_need = tacc_cycles(pick_atime); // R13
					next_cnt = 7'h00;
					next_addr = VME_ADDR[16:1]; // R2
				end
			end
			vsmd_pkg::ST_ACCESS: begin
				next_cnt = cnt + 7'h01;
				if (!ds_any) begin
					next_state = as_on ? vsmd_pkg::ST_HOLD : vsmd_pkg::ST_IDLE;
				end else if (cnt_done) begin
					next_state = vsmd_pkg::ST_ACK; // R19
				end
			end
			vsmd_pkg::ST_ACK: begin
				if (!ds_any) begin
					next_state = as_on ? vsmd_pkg::ST_HOLD : vsmd_pkg::ST_IDLE; // R19 R11
				end
			end
			vsmd_pkg::ST_HOLD: begin
				if (!as_on) begin
					next_state = vsmd_pkg::ST_IDLE;
				end else if (ds_any && rehit) begin
					next_state = vsmd_pkg::ST_ACCESS; // R11
					next_lane = ds_on;
					next_wr = cyc_wr;
					next_cnt = 7'h00;
				end
			end
			default: begin
				next_state = vsmd_pkg::ST_IDLE;
			end
		endcase
	end

	assign sel_any = (next_state != vsmd_pkg::ST_IDLE);

	// socket order in a block: pair*2 + 0 odd byte, pair*2 + 1 even byte
	genvar s;
	generate
		for (s = 0; s < NUM_BLOCKS * SOCKETS; s++) begin : gen_sock
			localparam int BLK = s / SOCKETS;
			localparam int PAIR = (s % SOCKETS) / 2;
			localparam int LANE = s % 2;
			assign next_ce_n[s] = ~(sel_any && next_blk[BLK] &&
				(next_pair == 2'(PAIR)) && next_lane[LANE]); // R10 R20
		end
	endgenerate

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state <= vsmd_pkg::ST_IDLE;
			sel_blk <= '0;
			sel_pair <= 2'h0;
			sel_lane <= 2'h0;
			sel_wr <= 1'b0;
			need_cnt <= 7'h01;
			cnt <= 7'h00;
		end else if (CLK_EN) begin
			state <= next_state;
			sel_blk <= next_blk;
			sel_pair <= next_pair;
			sel_lane <= next_lane;
			sel_wr <= next_wr;
			need_cnt <= next_need;
			cnt <= next_cnt;
		end
	end

	// memory strobes follow the next state so enable and count start together
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			MEM_CE_N <= '1;
			MEM_OE_N <= 1'b1;
			MEM_WE_N <= 1'b1;
			MEM_ADDR <= 16'h0000;
			ACCESS_LED <= '0;
			VME_DTACK_OE <= 1'b0;
			SECONDARY_CHIP_ENABLE <= '0;
		end else if (CLK_EN) begin
			MEM_CE_N <= next_ce_n; // R18
			MEM_OE_N <= ~((next_state == vsmd_pkg::ST_ACCESS ||
				next_state == vsmd_pkg::ST_ACK) && !next_wr);
			MEM_WE_N <= ~((next_state == vsmd_pkg::ST_ACCESS ||
				next_state == vsmd_pkg::ST_ACK) && next_wr);
			MEM_ADDR <= next_addr;
			ACCESS_LED <= sel_any ? next_blk : '0; // R15
			VME_DTACK_OE <= (next_state == vsmd_pkg::ST_ACK); // R19
			SECONDARY_CHIP_ENABLE <= next_sce; // R14
		end
	end

	// acknowledge is a driven low level, released by dropping the enable
	assign VME_DTACK_N = 1'b0; // R16

	// register slave answers the cycle after a request; writes land on that completing edge
	assign avs_req = (AVS_READ | AVS_WRITE) & ~avs_done;
	assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~avs_done;
	assign wr_cfg0 = avs_done & AVS_WRITE & (AVS_ADDRESS == `VSMD_REG_CFG0);
	assign wr_cfg1 = avs_done & AVS_WRITE & (AVS_ADDRESS == `VSMD_REG_CFG1);
	assign wr_cfg2 = avs_done & AVS_WRITE & (AVS_ADDRESS == `VSMD_REG_CFG2);

	assign status_word = {23'h000000, VME_DTACK_OE, state,
		POWER_FAIL, ACCESS_LED};
	assign rd_mux = (AVS_ADDRESS == `VSMD_REG_CFG0) ? {13'h0000, cfg_reg[0]} :
		(AVS_ADDRESS == `VSMD_REG_CFG1) ? {13'h0000, cfg_reg[1]} :
		(AVS_ADDRESS == `VSMD_REG_CFG2) ? {13'h0000, cfg_reg[2]} :
		(AVS_ADDRESS == `VSMD_REG_STATUS) ? status_word : 32'h00000000;

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			avs_done <= 1'b0;
			AVS_READDATA <= 32'h00000000;
		end else if (CLK_EN) begin
			avs_done <= avs_req;
			if (avs_req && AVS_READ) begin
				AVS_READDATA <= rd_mux;
			end
		end
	end

	// changing a block's setup mid-cycle affects the next selection and the second phase of a locked cycle
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			cfg_reg[0] <= `VSMD_CFG_RESET;
			cfg_reg[1] <= `VSMD_CFG_RESET;
			cfg_reg[2] <= `VSMD_CFG_RESET;
		end else if (CLK_EN) begin
			if (wr_cfg0) begin
				cfg_reg[0] <= AVS_WRITEDATA[CW-1:0];
			end
			if (wr_cfg1) begin
				cfg_reg[1] <= AVS_WRITEDATA[CW-1:0];
			end
			if (wr_cfg2) begin
				cfg_reg[2] <= AVS_WRITEDATA[CW-1:0];
			end
		end
	end
endmodule // vsmd_top
`default_nettype wire

// ---- sim/test_vsmd_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_vsmd_top;
	logic REF_CLK;
	logic SRST;
	logic [3:0] avs_a;
	logic avs_rd, avs_wr, avs_wait;
	logic [31:0] avs_wd, avs_q;
	logic [23:1] v_addr;
	logic [5:0] v_am;
	logic v_as_n, v_ds0_n, v_ds1_n, v_wr_n, v_iack_n;
	logic iackin_n, iackout_n, dt_n, dt_oe, pfail, dtack_w, clk_en;
	logic [3:0] bg_in, bg_out;
	logic [15:0] mem_a;
	logic [2:0] sce;
	logic [5:0] ams [8] = '{6'h39, 6'h3A, 6'h3D, 6'h3E, 6'h3B, 6'h29, 6'h2D, 6'h09};
	int errors;
	int num_checks;
	// the acknowledge line is pulled up whenever the board lets go of it
	assign dtack_w = dt_oe ? dt_n : 1'b1;
	vsmd_top vsmd_top_i (.REF_CLK(REF_CLK), .SRST(SRST), .CLK_EN(clk_en),
		.AVS_ADDRESS(avs_a), .AVS_READ(avs_rd), .AVS_WRITE(avs_wr), .AVS_WRITEDATA(avs_wd),
		.AVS_READDATA(avs_q), .AVS_WAITREQUEST(avs_wait), .VME_ADDR(v_addr), .VME_AM(v_am),
		.VME_AS_N(v_as_n), .VME_DS0_N(v_ds0_n), .VME_DS1_N(v_ds1_n), .VME_WRITE_N(v_wr_n),
		.VME_IACK_N(v_iack_n), .VME_IACKIN_N(iackin_n), .VME_IACKOUT_N(iackout_n),
		.VME_BG_IN_N(bg_in), .VME_BG_OUT_N(bg_out), .VME_DTACK_N(dt_n), .VME_DTACK_OE(dt_oe),
		.POWER_FAIL(pfail), .MEM_CE_N(), .MEM_OE_N(), .MEM_WE_N(), .MEM_ADDR(mem_a),
		.SECONDARY_CHIP_ENABLE(sce), .ACCESS_LED());
	vsmd_vme_master vme_i (.clk(REF_CLK), .dtack_n(dtack_w), .addr(v_addr), .am(v_am),
		.as_n(v_as_n), .ds0_n(v_ds0_n), .ds1_n(v_ds1_n), .write_n(v_wr_n), .iack_n(v_iack_n));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_lat(input int got, input int exp);
		num_checks++;
		if (got != exp) begin
			errors++;
			$display("mismatch %0t latency %0d expected %0d", $time, got, exp);
		end
	endtask
	task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		@(posedge REF_CLK);
		avs_a <= a;
		avs_wd <= d;
		avs_wr <= wr;
		avs_rd <= !wr;
		for (k = 0; k < 20; k++) begin
			@(posedge REF_CLK);
			if (avs_wait === 1'b0) break;
		end
		q = avs_q;
		avs_wr <= 1'b0;
		avs_rd <= 1'b0;
		if (k == 20) begin
			errors++;
			$display("mismatch %0t register bus hang", $time);
			stop_test();
		end
	endtask
	task automatic vme(input logic [23:0] a, input logic [5:0] m, input logic wr,
		input logic [1:0] ds, input logic ia, input int exp, input logic lk = 1'b0);
		int n;
		vme_i.access(a, m, wr, ds, ia, lk, n);
		chk_lat(n, exp);
	endtask
	initial begin
		REF_CLK = 1'b0;
		forever #4 REF_CLK = ~REF_CLK;
	end
	initial begin
		logic [31:0] q;
		errors = 0;
		num_checks = 0;
		{SRST, avs_rd, avs_wr, pfail, iackin_n, bg_in} = 9'h10F;
		avs_a = 4'h0;
		avs_wd = 32'h0;
		clk_en = 1'b1;
		repeat (12) @(posedge REF_CLK);
		SRST <= 1'b0;
		avs(0, 4'h4, 32'h0, q);
		chk_val(q, 32'h00053C00);
		avs(0, 4'h2, 32'h0, q);
		chk_val(q, 32'h0);
		// block 0: 8K units, any class, 100 ns; block 1: 64K read-only 500 ns;
		// block 2: 16K, supervisor data only, backed up, 200 ns
		avs(1, 4'h0, 32'h00003C04, q);
		avs(1, 4'h4, 32'h00057F10, q);
		avs(1, 4'h8, 32'hFFFA9520, q);
		avs(0, 4'h8, 32'h0, q);
		chk_val(q, 32'h00029520);
		$display("test registers done");
		vme(24'h042A46, 6'h3D, 0, 2'b11, 0, 13);
		chk_val({16'h0, mem_a}, 32'h1523);
		for (int i = 0; i < 8; i++) begin
			vme(24'h040000, ams[i], 0, 2'b01, 0, i < 4 ? 13 : -1);
		end
		vme(24'h050000, 6'h3D, 0, 2'b11, 0, -1);
		vme(24'h170000, 6'h3D, 0, 2'b01, 0, 63);
		vme(24'h100000, 6'h3D, 1, 2'b11, 0, -1);
		vme(24'h210000, 6'h3D, 0, 2'b10, 0, 25);
		vme(24'h210000, 6'h39, 0, 2'b10, 0, -1);
		vme(24'h210000, 6'h3E, 0, 2'b10, 0, -1);
		vme(24'h040000, 6'h3D, 0, 2'b11, 1, -1);
		vme(24'h04FFFE, 6'h3D, 1, 2'b10, 0, 13);
		// indivisible cycles: the read phase keeps the address strobe for the write phase
		vme(24'h040010, 6'h3D, 0, 2'b11, 0, 13, 1);
		vme(24'h040010, 6'h3D, 1, 2'b11, 0, 13);
		vme(24'h100000, 6'h3D, 0, 2'b11, 0, 63, 1);
		vme(24'h100000, 6'h3D, 1, 2'b11, 0, -1);
		$display("test decode done");
		chk_val({29'h0, sce}, 32'h7);
		clk_en <= 1'b0;
		pfail <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		chk_val({29'h0, sce}, 32'h7);
		clk_en <= 1'b1;
		repeat (2) @(posedge REF_CLK);
		chk_val({29'h0, sce}, 32'h3);
		avs(0, 4'hC, 32'h0, q);
		chk_val(q, 32'h00000018);
		vme(24'h210000, 6'h3D, 0, 2'b11, 0, -1);
		vme(24'h040000, 6'h3D, 0, 2'b11, 0, 13);
		pfail <= 1'b0;
		$display("test power fail done");
		for (int i = 0; i < 4; i++) begin
			@(posedge REF_CLK);
			bg_in <= 4'(i * 5);
			iackin_n <= i[0];
			@(posedge REF_CLK);
			chk_val({28'h0, bg_out}, 32'(i * 5));
			chk_val({31'h0, iackout_n}, 32'(i % 2));
		end
		$display("test daisy chain done");
		stop_test();
	end
endmodule // test_vsmd_top
bind vsmd_top vsmd_top_checker #(.NUM_BLOCKS(NUM_BLOCKS), .SOCKETS(SOCKETS)) chk_i (
	.REF_CLK(REF_CLK), .SRST(SRST), .VME_AM(VME_AM), .VME_DS0_N(VME_DS0_N),
	.VME_DS1_N(VME_DS1_N), .VME_WRITE_N(VME_WRITE_N), .VME_IACK_N(VME_IACK_N),
	.VME_IACKIN_N(VME_IACKIN_N),
	.VME_IACKOUT_N(VME_IACKOUT_N), .VME_BG_IN_N(VME_BG_IN_N), .VME_BG_OUT_N(VME_BG_OUT_N),
	.VME_DTACK_OE(VME_DTACK_OE), .MEM_CE_N(MEM_CE_N), .MEM_OE_N(MEM_OE_N),
	.MEM_WE_N(MEM_WE_N), .ACCESS_LED(ACCESS_LED));
`default_nettype wire

// ---- sim/vsmd_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsmd_top_checker #(
	parameter int NUM_BLOCKS = 3,
	parameter int SOCKETS = 8
) (
	input wire logic REF_CLK,
	input wire logic SRST,
	input wire logic [5:0] VME_AM,
	input wire logic VME_DS0_N,
	input wire logic VME_DS1_N,
	input wire logic VME_WRITE_N,
	input wire logic VME_IACK_N,
	input wire logic VME_IACKIN_N,
	input wire logic VME_IACKOUT_N,
	input wire logic [3:0] VME_BG_IN_N,
	input wire logic [3:0] VME_BG_OUT_N,
	input wire logic VME_DTACK_OE,
	input wire logic [NUM_BLOCKS*SOCKETS-1:0] MEM_CE_N,
	input wire logic MEM_OE_N,
	input wire logic MEM_WE_N,
	input wire logic [NUM_BLOCKS-1:0] ACCESS_LED
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	wire logic idle = &MEM_CE_N;
	wire logic am_ok = VME_AM inside {6'h39, 6'h3A, 6'h3D, 6'h3E};
	logic [7:0] cnt;
	logic odd_on;
	logic even_on;
	logic [NUM_BLOCKS-1:0] blk_on;
	always_comb begin
		odd_on = 1'b0;
		even_on = 1'b0;
		for (int i = 0; i < NUM_BLOCKS*SOCKETS; i++) begin
			if (i % 2 == 0) begin
				odd_on = odd_on | !MEM_CE_N[i];
			end else begin
				even_on = even_on | !MEM_CE_N[i];
			end
		end
		for (int b = 0; b < NUM_BLOCKS; b++) begin
			blk_on[b] = !(&MEM_CE_N[b*SOCKETS +: SOCKETS]);
		end
	end
	// saturates so a stuck cycle cannot wrap into a false early count
	always_ff @(posedge REF_CLK) begin
		if (SRST || idle) begin
			cnt <= 8'h00;
		end else if (cnt != 8'hFF) begin
			cnt <= cnt + 8'h01;
		end
	end
	sequence take_s;
		$fell(idle);
	endsequence
	sequence ack_s;
		$rose(VME_DTACK_OE);
	endsequence
	sequence lane_s;
		odd_on == !$past(VME_DS0_N) && even_on == !$past(VME_DS1_N);
	endsequence
	// read opens the outputs, write pulses the write enable, never both
	sequence dir_s;
		MEM_OE_N == !$past(VME_WRITE_N) && MEM_WE_N == $past(VME_WRITE_N);
	endsequence
	a_bg_pass: assert property (VME_BG_OUT_N == VME_BG_IN_N)
		else $error("grant chain broken");
	a_iack_pass: assert property (VME_IACKOUT_N == VME_IACKIN_N)
		else $error("acknowledge chain broken");
	a_iack_idle: assert property (idle && !VME_IACK_N |=> idle)
		else $error("selected on interrupt acknowledge");
	a_am_idle: assert property (idle && !am_ok |=> idle)
		else $error("selected on foreign modifier");
	a_ack_time: assert property (ack_s |-> cnt >= 8'h0D)
		else $error("acknowledge too early");
	a_ack_release: assert property (VME_DTACK_OE && VME_DS0_N && VME_DS1_N |=> !VME_DTACK_OE)
		else $error("acknowledge held after strobes");
	a_lane_map: assert property (take_s |-> lane_s)
		else $error("socket lane mismatch");
	a_strobe_dir: assert property (take_s |-> dir_s)
		else $error("memory strobe direction wrong");
	a_led_block: assert property (ACCESS_LED == blk_on)
		else $error("indicator mismatch");
	a_one_block: assert property ($onehot0(blk_on))
		else $error("two blocks selected");
endmodule // vsmd_top_checker
`default_nettype wire

// ---- sim/vsmd_vme_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module vsmd_vme_master (
	input wire logic clk,
	input wire logic dtack_n,
	output var logic [23:1] addr,
	output var logic [5:0] am,
	output var logic as_n,
	output var logic ds0_n,
	output var logic ds1_n,
	output var logic write_n,
	output var logic iack_n
);
	initial begin
		addr = '0;
		am = 6'h00;
		{as_n, ds0_n, ds1_n, write_n, iack_n} = 5'h1F;
	end
	// n is -1 when no acknowledge came; strobes are then dropped as a bus timeout would
	// lock keeps the address strobe low so the next call is the second phase of one cycle
	task automatic access(input logic [23:0] a, input logic [5:0] m, input logic wr,
		input logic [1:0] ds, input logic ia, input logic lock, output int n);
		n = -1;
		@(posedge clk);
		addr <= a[23:1];
		am <= m;
		write_n <= !wr;
		iack_n <= !ia;
		as_n <= 1'b0;
		{ds1_n, ds0_n} <= ~ds;
		@(posedge clk);
		for (int k = 0; k < 80; k++) begin
			@(posedge clk);
			if (dtack_n === 1'b0) begin
				n = k;
				break;
			end
		end
		{ds0_n, ds1_n} <= 2'h3;
		if (!lock) begin
			{as_n, write_n, iack_n} <= 3'h7;
			addr <= ~a[23:1];
			am <= ~m;
		end
		@(posedge clk);
	endtask
endmodule // vsmd_vme_master
`default_nettype wire
